// >>> core/timer_output_control.sv
// Output-control and input-filter slice of an eight-channel timer array.
// Assumes channel interrupt pulses come from counters on the same clock.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_out_defines.svh"

module timer_output_control
    import tmr_out_pkg::*;
#(
    parameter int CHANNELS = 8
)
(
    input wire logic clock,                            // 25 MHz clock
    input wire logic rstn,                             // Async reset, active low
    input wire logic ce,                               // Clock enable
    input wire logic [`ADDR_W-1:0] addr,               // Register byte address
    input wire logic [15:0] wdata,                     // Write data
    input wire logic wr,                               // Write strobe
    input wire logic rd,                               // Read strobe
    output logic [15:0] rdata,                         // Read data, cycle after rd
    input wire logic [CHANNELS-1:0] channel_interrupt_request, // Per-channel pulses
    output logic [CHANNELS-1:0] channel_output,        // Pin levels after polarity
    input wire logic timer_in_ch0,                     // Channel 0 input pin
    input wire logic timer_in_ch4,                     // Channel 4 input pin
    input wire logic timer_in_ch7,                     // Channel 7 input pin
    input wire logic serial_receive_2,                 // Serial receive pin
    output logic [CHANNELS-1:0] channel_input,         // Filtered inputs to counters; channel 7 unfiltered when swapped
    output logic serial_receive_filtered               // Serial receive, filtered only when swapped
);

    // ----------------------------------------------------------
    // Register file
    // ----------------------------------------------------------
    logic [15:0] pol_q;
    logic [15:0] mode_q;
    logic [15:0] oe_q;
    logic [15:0] out_q;
    logic [7:0] filt_q;
    logic [7:0] swap_q;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic [CHANNELS-1:0] raw_d;
    logic [CHANNELS-1:0] pol_used_q;
    logic [CHANNELS-1:0] pol_used_d;

    wire sel_pol = addr == `OUT_POL_ADDR;
    wire sel_mode = addr == `OUT_MODE_ADDR;
    wire sel_oe = addr == `OUT_ENABLE_ADDR;
    wire sel_out = addr == `OUT_VALUE_ADDR;
    wire sel_filt = addr == `FILTER_EN_ADDR;
    wire sel_swap = addr == `IN_SWAP_ADDR;
    wire swap_rx = swap_q[`SWAP_BIT];

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            pol_q <= `POL_RESET;
            mode_q <= `MODE_RESET;
            filt_q <= `FILTER_RESET;
            oe_q <= 16'h0000;
            swap_q <= 8'h00;
        end
        else if (ce && wr)
        begin
            // Unimplemented bits are dropped by masking
            if (sel_pol) pol_q <= wdata & `POL_MASK;
            if (sel_mode) mode_q <= wdata & `MODE_MASK;
            if (sel_filt) filt_q <= wdata[7:0] & `FILTER_MASK;
            if (sel_oe) oe_q <= wdata & `OE_MASK;
            if (sel_swap) swap_q <= wdata[7:0] & 8'h03;
        end
    end

    assign rdata_d = sel_pol ? pol_q :
                     sel_mode ? mode_q :
                     sel_oe ? oe_q :
                     sel_out ? out_q :
                     sel_filt ? {8'h00, filt_q} :
                     sel_swap ? {8'h00, swap_q} : 16'h0000;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            rdata_q <= 16'h0000;
        else if (ce)
            rdata_q <= rd ? rdata_d : 16'h0000;
    end

    assign rdata = rdata_q;

    // ----------------------------------------------------------
    // Raw output bit per channel
    // ----------------------------------------------------------
    genvar n;
    generate
        for (n = 0; n < CHANNELS; n++)
        begin : g_ch
            localparam int MASTER = (n == 0) ? 0 : n - 1;
            logic sw_wr;
            logic change;
            assign sw_wr = ce && wr && sel_out && !oe_q[n];
            always_comb
            begin
                raw_d[n] = out_q[n];
                if (sw_wr)
                    raw_d[n] = wdata[n];
                else if (oe_q[n] && !mode_q[n] && channel_interrupt_request[n])
                    raw_d[n] = ~out_q[n];
                else if (oe_q[n] && mode_q[n] && channel_interrupt_request[MASTER])
                    raw_d[n] = 1'b1;
                else if (oe_q[n] && mode_q[n] && channel_interrupt_request[n])
                    raw_d[n] = 1'b0;
            end
            assign change = raw_d[n] != out_q[n];
            // Polarity is latched only when the raw output moves
            assign pol_used_d[n] = change ? pol_q[n] : pol_used_q[n];
        end
    endgenerate

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            out_q <= 16'h0000;
            pol_used_q <= '0;
        end
        else if (ce)
        begin
            out_q[CHANNELS-1:0] <= raw_d;
            pol_used_q <= pol_used_d;
        end
    end

    assign channel_output = out_q[CHANNELS-1:0] ^ pol_used_q;

    // ----------------------------------------------------------
    // Input synchronisers and filters
    // ----------------------------------------------------------
    logic [3:0] meta_q;
    logic [3:0] sync_q;
    logic f0;
    logic f4;
    logic f7;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_q <= 4'h0;
            sync_q <= 4'h0;
        end
        else if (ce)
        begin
            meta_q <= {serial_receive_2, timer_in_ch7, timer_in_ch4, timer_in_ch0};
            sync_q <= meta_q;
        end
    end

    noise_filter u_f0 (.clock(clock), .rstn(rstn), .ce(ce), .enable(filt_q[0]),
        .din(sync_q[0]), .dout(f0));
    noise_filter u_f4 (.clock(clock), .rstn(rstn), .ce(ce), .enable(filt_q[4]),
        .din(sync_q[1]), .dout(f4));
    noise_filter u_f7 (.clock(clock), .rstn(rstn), .ce(ce), .enable(filt_q[7]),
        .din(swap_rx ? sync_q[3] : sync_q[2]), .dout(f7));

    always_comb
    begin
        channel_input = '0;
        channel_input[0] = f0;
        channel_input[4] = f4;
        channel_input[CHANNELS-1] = swap_rx ? sync_q[2] : f7;
    end

    assign serial_receive_filtered = swap_rx ? f7 : sync_q[3];

    // ----------------------------------------------------------
    // Checks
    // ----------------------------------------------------------
    oe_blocks_write_a: assert property (@(posedge clock) disable iff (!rstn)
        (ce && wr && sel_out && oe_q[4] && !channel_interrupt_request[4]
         && !channel_interrupt_request[3]) |=> $stable(out_q[4]))
        else $error("Software write reached enabled output");
    toggle_master_a: assert property (@(posedge clock) disable iff (!rstn)
        (ce && oe_q[0] && !mode_q[0] && channel_interrupt_request[0]
         && !(wr && sel_out)) |=> out_q[0] != $past(out_q[0]))
        else $error("Master output did not toggle");
    slave_set_a: assert property (@(posedge clock) disable iff (!rstn)
        (ce && oe_q[7] && mode_q[7] && channel_interrupt_request[6]) |=> out_q[7])
        else $error("Slave output not set by master");
    slave_clear_a: assert property (@(posedge clock) disable iff (!rstn)
        (ce && oe_q[7] && mode_q[7] && channel_interrupt_request[7]
         && !channel_interrupt_request[6]) |=> !out_q[7])
        else $error("Slave output not cleared");
    pol_deferred_a: assert property (@(posedge clock) disable iff (!rstn)
        (ce && raw_d[4] == out_q[4]) |=> $stable(pol_used_q[4]))
        else $error("Polarity changed without output edge");
    pol_apply_a: assert property (@(posedge clock) disable iff (!rstn)
        (ce && raw_d[4] != out_q[4]) |=> channel_output[4] == (out_q[4] ^ $past(pol_q[4])))
        else $error("Polarity not applied at output edge");
    mask_pol_a: assert property (@(posedge clock) disable iff (!rstn)
        (pol_q & ~`POL_MASK) == 16'h0000)
        else $error("Unimplemented polarity bit set");
    mask_filt_a: assert property (@(posedge clock) disable iff (!rstn)
        (filt_q & ~`FILTER_MASK) == 8'h00 && (mode_q & ~`MODE_MASK) == 16'h0000)
        else $error("Unimplemented mode or filter bit set");
    bypass_path_a: assert property (@(posedge clock) disable iff (!rstn)
        (!filt_q[0]) |-> channel_input[0] == sync_q[0])
        else $error("Bypassed filter altered input");

endmodule // timer_output_control
`default_nettype wire

// >>> include/tmr_out_defines.svh
// Offsets, field positions, reset values and timing counts of the
// timer output-control and input-filter slice.
// Assumes byte addresses on a plain register port, 20-bit address.
`ifndef TMR_OUT_DEFINES_SVH
`define TMR_OUT_DEFINES_SVH

`define ADDR_W 20
`define FILTER_EN_ADDR 20'hF0071
`define OUT_MODE_ADDR 20'hF01BE
`define OUT_POL_ADDR 20'hF01BC
`define OUT_ENABLE_ADDR 20'hF01BA
`define OUT_VALUE_ADDR 20'hF01B8
`define IN_SWAP_ADDR 20'hF0073

`define POL_MASK 16'h0090
`define MODE_MASK 16'h0090
`define OE_MASK 16'h0091
`define FILTER_MASK 8'h91
`define SWAP_BIT 1

`define POL_RESET 16'h0000
`define MODE_RESET 16'h0000
`define FILTER_RESET 8'h00
`define FILTER_SAMPLES 2

`endif

// >>> include/tmr_out_pkg.sv
// Types shared by the timer output-control slice.
// Assumes the defines header for numeric values.
package tmr_out_pkg;
    typedef enum logic [1:0] {
        FILT_IDLE,
        FILT_WAIT
    } filt_state_t;
endpackage

// >>> core/noise_filter.sv
// Noise filter for one timer input pin.
// Assumes the pin is already synchronised to clock.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_out_defines.svh"

module noise_filter
    import tmr_out_pkg::*;
(
    input wire logic clock,   // Operating clock
    input wire logic rstn,    // Async reset, active low
    input wire logic ce,      // Clock enable
    input wire logic enable,  // Filter on when high
    input wire logic din,     // Synchronised pin level
    output logic dout         // Filtered or bypassed level
);

    logic level_q;
    logic level_d;
    logic cand_q;
    filt_state_t state_q;
    filt_state_t state_d;
    logic cand_d;

    // ----------------------------------------------------------
    // Two equal samples before a new level is passed
    // ----------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        level_d = level_q;
        cand_d = cand_q;
        case (state_q)
            FILT_IDLE:
            begin
                if (din != level_q)
                begin
                    cand_d = din;
                    state_d = FILT_WAIT;
                end
            end
            FILT_WAIT:
            begin
                if (din == cand_q)
                begin
                    level_d = cand_q;
                end
                state_d = FILT_IDLE;
            end
            default:
            begin
                state_d = FILT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= FILT_IDLE;
            level_q <= 1'b0;
            cand_q <= 1'b0;
        end
        else if (ce)
        begin
            state_q <= state_d;
            level_q <= level_d;
            cand_q <= cand_d;
        end
    end

    assign dout = enable ? level_q : din;

    filt_hold_a: assert property (@(posedge clock) disable iff (!rstn)
        (ce && enable && state_q == FILT_IDLE && din != level_q) ##1 (ce && din != $past(din))
        |=> $stable(level_q))
        else $error("Filter passed a one-sample glitch");

endmodule // noise_filter
`default_nettype wire

// >>> tb/pin_model.sv
// Model of the external timer input pins and the serial receive pin.
// Assumes the bench calls pulse from a process tied to clock.
`timescale 1ns/1ps
`default_nettype none

module pin_model
(
    input wire logic clock, // Bench clock
    output logic [3:0] pins // Channel 0, 4, 7 inputs, serial receive
);
    // Pins idle high, like an idle serial line
    initial
    begin
        pins = 4'hF;
    end

    // Flips one pin for len cycles, then restores it, all on clock edges
    task automatic pulse(input int idx, input int len);
        @(posedge clock);
        pins[idx] <= ~pins[idx];
        repeat (len) @(posedge clock);
        pins[idx] <= ~pins[idx];
    endtask
endmodule // pin_model

`default_nettype wire

// >>> tb/timer_output_control_tb_top.sv
// Self-checking bench of the timer output-control and input-filter slice.
// Assumes the defines header for offsets and masks, and pin_model.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_out_defines.svh"

module timer_output_control_tb_top;
    logic clock, rstn, ce, wr, rd, ser_f;
    logic [19:0] addr;
    logic [15:0] wdata, rdata, r, v;
    logic [7:0] irq, chan_out, chan_in;
    logic [3:0] pins;
    wire [3:0] obs = {ser_f, chan_in[7], chan_in[4], chan_in[0]};
    logic [7:0] pol, mode, oe, outv, latch;
    int fail_count, comparisons;
    int chs[3] = '{0, 4, 7};
    logic [19:0] regs[3] = '{`OUT_POL_ADDR, `OUT_MODE_ADDR, `FILTER_EN_ADDR};
    logic [15:0] masks[3] = '{16'h0090, 16'h0090, 16'h0091};
    logic [15:0] mds[2] = '{16'h0000, 16'h0090};

    timer_output_control #(.CHANNELS(8)) uut
    (
        .clock(clock), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .channel_interrupt_request(irq), .channel_output(chan_out),
        .timer_in_ch0(pins[0]), .timer_in_ch4(pins[1]), .timer_in_ch7(pins[2]),
        .serial_receive_2(pins[3]), .channel_input(chan_in), .serial_receive_filtered(ser_f)
    );
    pin_model pins_u (.clock(clock), .pins(pins));

    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr_reg(input logic [19:0] a, input logic [15:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [19:0] a, output logic [15:0] d);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    // Model: a new polarity is taken up only when the raw output bit moves
    task automatic set_raw(input int ch, input logic v);
        if (outv[ch] !== v)
        begin
            outv[ch] = v;
            latch[ch] = pol[ch];
        end
    endtask
    task automatic cmp_out();
        repeat (2) @(posedge clock);
        #1;
        check({8'h00, chan_out & 8'h91}, {8'h00, (outv ^ latch) & 8'h91}, "output");
    endtask
    task automatic pol_write(input logic [15:0] d);
        wr_reg(`OUT_POL_ADDR, d & 16'h0090);
        pol = d[7:0] & 8'h90;
        cmp_out();
    endtask
    task automatic sw_out(input logic [7:0] v);
        wr_reg(`OUT_VALUE_ADDR, {8'h00, v});
        foreach (chs[i])
            if (!oe[chs[i]])
                set_raw(chs[i], v[chs[i]]);
        cmp_out();
    endtask
    task automatic irq_step(input logic [7:0] v);
        int m;
        @(posedge clock);
        irq <= v;
        @(posedge clock);
        irq <= 8'h00;
        foreach (chs[i])
        begin
            m = (chs[i] == 0) ? 0 : chs[i] - 1;
            if (!mode[chs[i]] && v[chs[i]])
                set_raw(chs[i], ~outv[chs[i]]);
            else if (mode[chs[i]] && v[m])
                set_raw(chs[i], 1'b1);
            else if (mode[chs[i]] && v[chs[i]])
                set_raw(chs[i], 1'b0);
        end
        cmp_out();
    endtask
    task automatic glitch_test(input int s, input int len, input logic exp, input string what);
        logic seen;
        logic base;
        seen = 1'b0;
        #1;
        base = obs[s];
        fork
            pins_u.pulse(s, len);
        join_none
        repeat (14)
        begin
            @(posedge clock);
            #1;
            if (obs[s] !== base)
                seen = 1'b1;
        end
        check({15'h0000, seen}, {15'h0000, exp}, what);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        {rstn, wr, rd, irq, addr, wdata} = '0;
        ce = 1'b1;
        {pol, mode, oe, outv, latch} = '0;
        fail_count = 0;
        comparisons = 0;
        void'($urandom(32'h020C));
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        repeat (4) @(posedge clock);
        #1;
        check({8'h00, chan_out}, 16'h0000, "output after reset");
        foreach (regs[i])
        begin
            rd_reg(regs[i], r);
            check(r, 16'h0000, "reset value");
            v = 16'($urandom) & masks[i];
            wr_reg(regs[i], v);
            rd_reg(regs[i], r);
            check(r, v, "read back");
            wr_reg(regs[i], 16'h0000);
        end
        wr_reg(20'hF0000, 16'hFFFF);
        rd_reg(20'hF0000, r);
        check(r, 16'h0000, "unmapped read");
        $display("test registers done");
        repeat (4)
        begin
            pol_write(16'($urandom));
            sw_out(8'($urandom) & 8'h91);
        end
        wr_reg(`OUT_ENABLE_ADDR, 16'h0091);
        oe = 8'h91;
        sw_out(~outv & 8'h91);
        // Interrupts while the clock enable is low must not move any output
        @(posedge clock);
        ce <= 1'b0;
        irq <= 8'h91;
        @(posedge clock);
        irq <= 8'h00;
        ce <= 1'b1;
        cmp_out();
        $display("test software output done");
        foreach (mds[k])
        begin
            wr_reg(`OUT_MODE_ADDR, mds[k]);
            mode = mds[k][7:0];
            repeat (40)
            begin
                if ($urandom_range(3) == 0)
                    pol_write(16'($urandom));
                irq_step(8'($urandom) & 8'hD9);
            end
        end
        $display("test timer output done");
        for (int s = 0; s < 3; s++)
            for (int en = 0; en < 2; en++)
            begin
                wr_reg(`FILTER_EN_ADDR, (en != 0) ? 16'h0091 : 16'h0000);
                glitch_test(s, 1, en == 0, "glitch");
                glitch_test(s, 3, 1'b1, "steady level");
            end
        wr_reg(`IN_SWAP_ADDR, 16'h0000);
        glitch_test(3, 1, 1'b1, "serial unswapped");
        wr_reg(`IN_SWAP_ADDR, 16'h0002);
        glitch_test(3, 1, 1'b0, "serial swapped glitch");
        glitch_test(3, 3, 1'b1, "serial swapped level");
        glitch_test(2, 1, 1'b1, "timer pin bypassed when swapped");
        $display("test input filter done");
        tally_and_finish();
    end

    // Cuts a hung run short
    initial
    begin
        #400000;
        fail_count++;
        $display("CHECK FAILED at %0t: run did not finish in time", $time);
        tally_and_finish();
    end
endmodule // timer_output_control_tb_top

`default_nettype wire
